// ===== rtl/pts_cfg.svh
// register offsets, field positions and reset values of the stamp readout
// assumes inclusion by the readout design file of this block; the package does not include it
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH

// ==========================================================
// register offsets on the timestamp page
`define PTS_OFS_RD_SUM 5'h1a
`define PTS_OFS_WR_SUM 5'h1b
`define PTS_OFS_TX_STAMP 5'h1c
`define PTS_OFS_RX_STAMP 5'h1d
`define PTS_OFS_EVT_STATUS 5'h1e
`define PTS_OFS_EVT_DATA 5'h1f

// ==========================================================
// reset values
`define PTS_SUM_RST 16'h0000
`define PTS_WORD_RST 16'h0000

// ==========================================================
// event status field positions
`define PTS_ST_MISSED_MSB 10
`define PTS_ST_MISSED_LSB 8
`define PTS_ST_MULT_BIT 1

// ==========================================================
// sequencer word positions and the missed count limit
`define PTS_TX_LAST 2'h3
`define PTS_RX_LAST 3'h5
`define PTS_ED_LAST 3'h4
`define PTS_ED_FIRST_SINGLE 3'h1
`define PTS_ED_FIRST_MULT 3'h0
`define PTS_MISSED_MAX 3'h7

`endif

// ===== rtl/pts_pkg.sv
// types and helpers shared by the stamp readout files
// assumes pts_cfg.svh is on the include path
`default_nettype none
package pts_pkg;

  // ==========================================================
  // queue entry layouts
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } pts_tx_ent_t;

  typedef struct packed {
    logic [3:0] msg_type;
    logic [11:0] src_hash;
    logic [15:0] seq_id;
    logic [31:0] sec;
    logic [29:0] ns;
  } pts_rx_ent_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] ext;
    logic [31:0] sec;
    logic [29:0] ns;
  } pts_evt_ent_t;

  // ==========================================================
  // one's complement 16-bit add with end-around carry
  function automatic logic [15:0] pts_oc_add(input logic [15:0] a,
                                             input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // lowest set bit index of an eight-bit mask
  function automatic logic [2:0] pts_lowest(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        idx = i[2:0];
      end
    end
    return idx;
  endfunction

endpackage
`default_nettype wire

// ===== rtl/pts_q_if.sv
// carrier between the readout logic and one stamp queue
// assumes both ends run on the same core clock
`default_nettype none
interface pts_q_if #(
  parameter int W = 62,
  parameter int DW = 2
);
  logic push;
  logic [W-1:0] push_data;
  logic pop;
  logic [W-1:0] head;
  logic avail;
  logic [DW-1:0] drops;

  modport store (
    input push, push_data, pop,
    output head, avail, drops
  );
  modport user (
    output push, push_data, pop,
    input head, avail, drops
  );
endinterface
`default_nettype wire

// ===== rtl/pts_stamp_queue.sv
// small stamp queue with a saturating count of dropped entries
// assumes push and pop come from logic on the same clock
`default_nettype none
module pts_stamp_queue #(
  parameter int W = 62,
  parameter int DEPTH = 4,
  parameter int DW = 2
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // queue port
  pts_q_if.store q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [DW-1:0] DMAX = '1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [DW-1:0] drops;
  } pts_qst_t;

  pts_qst_t st;
  pts_qst_t next_st;
  logic do_pop;
  logic do_push;
  logic dropped;

  // ==========================================================
  // queue update
  always_comb begin
    next_st = st;
    do_pop = q.pop && (st.cnt != '0);
    // a full queue loses the new stamp unless the head pops in the same cycle; it never overwrites the head
    do_push = q.push && ((st.cnt != FULL) || do_pop);
    dropped = q.push && !do_push;
    if (do_push) begin
      next_st.mem[st.wp] = q.push_data;
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (do_pop) begin
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
      next_st.drops = '0;
    end
    next_st.cnt = st.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    // a popping cycle never drops a push, so the count restarts at zero
    if (dropped && next_st.drops != DMAX) begin
      next_st.drops = next_st.drops + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q.head = st.mem[st.rp];
  assign q.avail = (st.cnt != '0);
  assign q.drops = st.drops;

  // ==========================================================
  // checks
  a_drop_saturate: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (st.drops == DMAX && !q.pop) |=> (st.drops == DMAX))
    else $error("drop count left saturation without a pop");
endmodule
`default_nettype wire

// ===== rtl/pts_readout.sv
// stamp readout registers: checksums, tx/rx/event stamp sequencers
// assumes register accesses come from the page logic on the core clock
`include "pts_cfg.svh"
`default_nettype none
module pts_readout
  import pts_pkg::*;
#(
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 4,
  parameter int EVT_DEPTH = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register access from the page logic
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_frame,
  input wire logic i_page_sel,
  input wire logic [15:0] i_page_rdata,
  // transmit stamp capture
  input wire logic i_tx_valid,
  input wire logic [29:0] i_tx_ns,
  input wire logic [31:0] i_tx_sec,
  // receive stamp capture
  input wire logic i_rx_valid,
  input wire logic [29:0] i_rx_ns,
  input wire logic [31:0] i_rx_sec,
  input wire logic [15:0] i_rx_seq,
  input wire logic [3:0] i_rx_type,
  input wire logic [11:0] i_rx_hash,
  // event stamp capture
  input wire logic i_evt_valid,
  input wire logic [29:0] i_evt_ns,
  input wire logic [31:0] i_evt_sec,
  input wire logic [7:0] i_evt_det,
  input wire logic [7:0] i_evt_rise,
  input wire logic [7:0] i_evt_missed_mask,
  input wire logic [2:0] i_evt_missed,
  // read answer and held event flag
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_evt_held
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] rd_sum;
    logic [15:0] wr_sum;
    logic [15:0] rdata;
    logic rvalid;
    logic [1:0] tx_pos;
    logic [2:0] rx_pos;
    logic [2:0] ed_pos;
    pts_evt_ent_t cur;
    logic cur_valid;
    logic [61:0] last_ts;
    logic have_last;
  } pts_st_t;

  pts_st_t st;
  pts_st_t next_st;

  pts_q_if #(.W($bits(pts_tx_ent_t)), .DW(2)) tx_q ();
  pts_q_if #(.W($bits(pts_rx_ent_t)), .DW(2)) rx_q ();
  pts_q_if #(.W($bits(pts_evt_ent_t)), .DW(3)) ev_q ();

  pts_stamp_queue #(.W($bits(pts_tx_ent_t)), .DEPTH(TX_DEPTH), .DW(2))
    u_tx_queue (.i_core_clk(i_core_clk), .i_reset(i_reset), .q(tx_q));
  pts_stamp_queue #(.W($bits(pts_rx_ent_t)), .DEPTH(RX_DEPTH), .DW(2))
    u_rx_queue (.i_core_clk(i_core_clk), .i_reset(i_reset), .q(rx_q));
  pts_stamp_queue #(.W($bits(pts_evt_ent_t)), .DEPTH(EVT_DEPTH), .DW(3))
    u_evt_queue (.i_core_clk(i_core_clk), .i_reset(i_reset), .q(ev_q));

  pts_tx_ent_t tx_head;
  pts_rx_ent_t rx_head;
  pts_evt_ent_t ev_head;
  pts_evt_ent_t ev_new;
  logic rd;
  logic wr;
  logic [15:0] rword;
  logic [3:0] missed_sum;
  logic [7:0] pick_mask;
  logic [2:0] unit;

  assign tx_head = pts_tx_ent_t'(tx_q.head);
  assign rx_head = pts_rx_ent_t'(rx_q.head);
  assign ev_head = pts_evt_ent_t'(ev_q.head);

  // ==========================================================
  // capture side: build queue entries
  always_comb begin
    tx_q.push = i_tx_valid;
    tx_q.push_data = {i_tx_sec, i_tx_ns};
    rx_q.push = i_rx_valid;
    rx_q.push_data = {i_rx_type, i_rx_hash, i_rx_seq, i_rx_sec, i_rx_ns};
    // prefer units that lost events before this stamp
    pick_mask = ((i_evt_det & i_evt_missed_mask) != 8'h00) ?
                (i_evt_det & i_evt_missed_mask) : i_evt_det;
    unit = pts_lowest(pick_mask);
    ev_new = '0;
    ev_new.ns = i_evt_ns;
    ev_new.sec = i_evt_sec;
    for (int i = 0; i < 8; i++) begin
      ev_new.ext[2*i] = i_evt_det[i];
      ev_new.ext[2*i+1] = i_evt_rise[i];
    end
    ev_new.status[10:8] = i_evt_missed;
    // first stamp after reset reports all four words as new
    if (!st.have_last || i_evt_sec[31:16] != st.last_ts[61:46]) begin
      ev_new.status[7:6] = 2'h3;
    end else if (i_evt_sec[15:0] != st.last_ts[45:30]) begin
      ev_new.status[7:6] = 2'h2;
    end else if (i_evt_ns[29:16] != st.last_ts[29:16]) begin
      ev_new.status[7:6] = 2'h1;
    end else begin
      ev_new.status[7:6] = 2'h0;
    end
    ev_new.status[5] = i_evt_rise[unit];
    ev_new.status[4:2] = unit;
    ev_new.status[1] = ($countones(i_evt_det) > 1);
    ev_new.status[0] = 1'b1;
    ev_q.push = i_evt_valid;
    ev_q.push_data = ev_new;
  end

  // ==========================================================
  // register side
  always_comb begin
    next_st = st;
    tx_q.pop = 1'b0;
    rx_q.pop = 1'b0;
    ev_q.pop = 1'b0;
    rword = `PTS_WORD_RST;
    rd = i_reg_rd && i_page_sel;
    // one access per cycle; a read wins a clash
    wr = i_reg_wr && i_page_sel && !rd;
    // queue drops add to the stored miss count, sticking at seven
    missed_sum = {1'b0, ev_head.status[`PTS_ST_MISSED_MSB:
                                       `PTS_ST_MISSED_LSB]} +
                 {1'b0, ev_q.drops};
    if (i_evt_valid) begin
      next_st.last_ts = {i_evt_sec, i_evt_ns};
      next_st.have_last = 1'b1;
    end
    if (rd) begin
      unique case (i_reg_addr)
        `PTS_OFS_RD_SUM: begin
          rword = st.rd_sum;
        end
        `PTS_OFS_WR_SUM: begin
          rword = st.wr_sum;
        end
        `PTS_OFS_TX_STAMP: begin
          if (tx_q.avail) begin
            unique case (st.tx_pos)
              2'h0: rword = tx_head.ns[15:0];
              2'h1: rword = {tx_q.drops, tx_head.ns[29:16]};
              2'h2: rword = tx_head.sec[15:0];
              2'h3: rword = tx_head.sec[31:16];
            endcase
            if (st.tx_pos == `PTS_TX_LAST) begin
              next_st.tx_pos = 2'h0;
              tx_q.pop = 1'b1;
            end else begin
              next_st.tx_pos = st.tx_pos + 2'h1;
            end
          end
        end
        `PTS_OFS_RX_STAMP: begin
          if (rx_q.avail) begin
            unique case (st.rx_pos)
              3'h0: rword = rx_head.ns[15:0];
              3'h1: rword = {rx_q.drops, rx_head.ns[29:16]};
              3'h2: rword = rx_head.sec[15:0];
              3'h3: rword = rx_head.sec[31:16];
              3'h4: rword = rx_head.seq_id;
              default: rword = {rx_head.msg_type, rx_head.src_hash};
            endcase
            if (st.rx_pos >= `PTS_RX_LAST) begin
              next_st.rx_pos = 3'h0;
              rx_q.pop = 1'b1;
            end else begin
              next_st.rx_pos = st.rx_pos + 3'h1;
            end
          end
        end
        `PTS_OFS_EVT_STATUS: begin
          if (ev_q.avail) begin
            rword = ev_head.status;
            rword[`PTS_ST_MISSED_MSB:`PTS_ST_MISSED_LSB] =
              (missed_sum > 4'h7) ? `PTS_MISSED_MAX
                                  : missed_sum[2:0];
            next_st.cur = ev_head;
            next_st.cur_valid = 1'b1;
            next_st.ed_pos = ev_head.status[`PTS_ST_MULT_BIT] ?
              `PTS_ED_FIRST_MULT : `PTS_ED_FIRST_SINGLE;
            ev_q.pop = 1'b1;
          end else begin
            rword = `PTS_WORD_RST;
            next_st.cur_valid = 1'b0;
          end
        end
        `PTS_OFS_EVT_DATA: begin
          // skipped trailing words are simply never read
          if (st.cur_valid) begin
            unique case (st.ed_pos)
              3'h0: rword = st.cur.ext;
              3'h1: rword = st.cur.ns[15:0];
              3'h2: rword = {2'b00, st.cur.ns[29:16]};
              3'h3: rword = st.cur.sec[15:0];
              default: rword = st.cur.sec[31:16];
            endcase
            if (st.ed_pos >= `PTS_ED_LAST) begin
              next_st.ed_pos = st.cur.status[`PTS_ST_MULT_BIT] ?
                `PTS_ED_FIRST_MULT : `PTS_ED_FIRST_SINGLE;
            end else begin
              next_st.ed_pos = st.ed_pos + 3'h1;
            end
          end
        end
        default: begin
          rword = i_page_rdata;
        end
      endcase
    end
    next_st.rdata = rword;
    next_st.rvalid = rd;
    // read sum
    if (rd && i_reg_addr == `PTS_OFS_RD_SUM) begin
      next_st.rd_sum = `PTS_SUM_RST;
    end else if (rd && !i_reg_frame) begin
      next_st.rd_sum = pts_oc_add(st.rd_sum, rword);
    end
    // write sum
    if (rd && i_reg_addr == `PTS_OFS_WR_SUM) begin
      next_st.wr_sum = `PTS_SUM_RST;
    end else if (wr && !i_reg_frame) begin
      next_st.wr_sum = pts_oc_add(st.wr_sum, i_reg_wdata);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.rdata;
  assign o_reg_rvalid = st.rvalid;
  assign o_evt_held = st.cur_valid;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_rd(logic [4:0] a);
    i_reg_rd && i_page_sel && i_reg_addr == a;
  endsequence

  sequence s_mgmt_rd(logic [4:0] a);
    s_rd(a) ##0 !i_reg_frame;
  endsequence

  a_rd_sum_clear: assert property (s_rd(`PTS_OFS_RD_SUM) |=>
    st.rd_sum == 16'h0000 && o_reg_rdata == $past(st.rd_sum))
    else $error("read sum not cleared or returned wrongly");

  a_wr_sum_clear: assert property (s_rd(`PTS_OFS_WR_SUM) |=>
    st.wr_sum == 16'h0000)
    else $error("write sum not cleared on read");

  a_rd_sum_adds: assert property (s_mgmt_rd(`PTS_OFS_TX_STAMP) |=>
    st.rd_sum == pts_oc_add($past(st.rd_sum), o_reg_rdata))
    else $error("read sum missed a read word");

  a_cross_check: assert property (s_mgmt_rd(`PTS_OFS_WR_SUM) |=>
    st.rd_sum == pts_oc_add($past(st.rd_sum), $past(st.wr_sum)))
    else $error("write sum read not added into read sum");

  a_frame_quiet: assert property ((i_reg_frame && i_page_sel &&
    ((i_reg_rd && i_reg_addr != `PTS_OFS_RD_SUM) ||
     (i_reg_wr && !i_reg_rd))) |=>
    $stable(st.rd_sum) && (st.wr_sum == 16'h0000 || $stable(st.wr_sum)))
    else $error("control frame access changed a checksum");

  a_wr_sum_adds: assert property ((i_reg_wr && !i_reg_rd &&
    i_page_sel && !i_reg_frame && i_reg_addr == `PTS_OFS_RD_SUM) |=>
    st.wr_sum == pts_oc_add($past(st.wr_sum), $past(i_reg_wdata)))
    else $error("write to read sum not added into write sum");

  a_tx_first_word: assert property ((s_rd(`PTS_OFS_TX_STAMP) ##0
    tx_q.avail && st.tx_pos == 2'h0) |=>
    o_reg_rdata == $past(tx_head.ns[15:0]) && st.tx_pos == 2'h1)
    else $error("transmit stamp order broken");

  a_tx_wraps: assert property ((s_rd(`PTS_OFS_TX_STAMP) ##0
    tx_q.avail && st.tx_pos == 2'h3) |=> st.tx_pos == 2'h0)
    else $error("transmit sequencer did not restart");

  a_rx_last_word: assert property ((s_rd(`PTS_OFS_RX_STAMP) ##0
    rx_q.avail && st.rx_pos == 3'h5) |=>
    o_reg_rdata == $past({rx_head.msg_type, rx_head.src_hash}))
    else $error("receive type and hash word wrong");

  a_status_empty: assert property ((s_rd(`PTS_OFS_EVT_STATUS) ##0
    !ev_q.avail) |=> o_reg_rdata == 16'h0000 && !st.cur_valid)
    else $error("status not zero without an event");

  a_status_rsvd: assert property (s_rd(`PTS_OFS_EVT_STATUS) |=>
    o_reg_rdata[15:11] == 5'h00 && o_reg_rvalid)
    else $error("status reserved bits not zero");

  a_edata_top: assert property ((s_rd(`PTS_OFS_EVT_DATA) ##0
    st.cur_valid && st.ed_pos == 3'h2) |=>
    o_reg_rdata[15:14] == 2'b00 && st.ed_pos == 3'h3)
    else $error("event ns high word not zero-topped");
endmodule
`default_nettype wire

// ===== verification/pts_host_model.sv
// management host model: issues page register reads and writes
// assumes the readout answers a taken read one cycle later with rvalid
`default_nettype none
module pts_host_model (
  // clock
  input wire logic i_core_clk,
  // read answer from the readout
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  // register access to the readout
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [4:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  output logic o_reg_frame,
  output logic o_page_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle state
  initial begin
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_addr = 5'h00;
    o_reg_wdata = 16'h0000;
    o_reg_frame = 1'b0;
    o_page_sel = 1'b0;
  end

  // ==========================================================
  // access tasks, driven on the falling edge
  // released lines go to the inverse so stale values cannot pass
  task automatic rd(input logic [4:0] a, input logic fr, input logic pg,
                    output logic [15:0] d, output logic v);
    @(negedge i_core_clk);
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    o_reg_frame = fr;
    o_page_sel = pg;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    v = i_reg_rvalid;
    d = i_reg_rdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] wd,
                    input logic fr);
    @(negedge i_core_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = wd;
    o_reg_frame = fr;
    o_page_sel = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// ===== verification/pts_readout_tb.sv
// self-checking bench of the stamp readout registers
// assumes pts_readout and pts_host_model are compiled before it
`default_nettype none
`define CHK(nm, exp, got) \
  begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module pts_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, fr, pg, rv, eh, txv, rxv, evv, v;
  logic [4:0] addr;
  logic [15:0] wd, prd, rdat, rseq, d;
  logic [29:0] tns, rns, ens;
  logic [31:0] tsec, rsec, esec;
  logic [3:0] rtyp;
  logic [11:0] rhash;
  logic [7:0] edet, erise, emask;
  logic [2:0] emiss;
  logic [15:0] etab [6];
  int failures, n_tests;

  // ==========================================================
  // instances, small queues so overflow is quick to reach
  pts_host_model host (.i_core_clk(clk), .i_reg_rdata(rdat),
    .i_reg_rvalid(rv), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(addr),
    .o_reg_wdata(wd), .o_reg_frame(fr), .o_page_sel(pg));
  pts_readout #(.TX_DEPTH(2), .RX_DEPTH(2), .EVT_DEPTH(2)) uut (
    .i_core_clk(clk), .i_reset(rst), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_frame(fr),
    .i_page_sel(pg), .i_page_rdata(prd), .i_tx_valid(txv),
    .i_tx_ns(tns), .i_tx_sec(tsec), .i_rx_valid(rxv), .i_rx_ns(rns),
    .i_rx_sec(rsec), .i_rx_seq(rseq), .i_rx_type(rtyp),
    .i_rx_hash(rhash), .i_evt_valid(evv), .i_evt_ns(ens),
    .i_evt_sec(esec), .i_evt_det(edet), .i_evt_rise(erise),
    .i_evt_missed_mask(emask), .i_evt_missed(emiss),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_evt_held(eh));

  // ==========================================================
  // helpers
  function automatic logic [15:0] sw(input logic [29:0] n,
      input logic [31:0] s, input logic [1:0] ov, input int k);
    case (k)
      0: return n[15:0];
      1: return {ov, n[29:16]};
      2: return s[15:0];
      default: return s[31:16];
    endcase
  endfunction

  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic f, input logic [15:0] exp);
    host.rd(a, f, 1'b1, d, v);
    `CHK({nm, " rvalid"}, 1'b1, v)
    `CHK(nm, exp, d)
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    finish_test();
  end

  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    prd = 16'h8001;
    {txv, rxv, evv, emiss} = '0;
    {tns, tsec, rns, rsec, ens, esec} = '0;
    {rseq, rtyp, rhash, edet, erise, emask} = '0;
    etab = '{16'hc100, 16'h5678, 16'h3abd, 16'h0002, 16'h0001, 16'hc100};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // empty state after reset
    rchk("read sum", 5'h1a, 1'b0, 16'h0000);
    rchk("tx empty", 5'h1c, 1'b0, 16'h0000);
    rchk("rx empty", 5'h1d, 1'b0, 16'h0000);
    rchk("status empty", 5'h1e, 1'b0, 16'h0000);
    rchk("data empty", 5'h1f, 1'b0, 16'h0000);
    `CHK("held", 1'b0, eh)
    host.rd(5'h1c, 1'b0, 1'b0, d, v);
    `CHK("page off rvalid", 1'b0, v)
    $display("test reset done");
    // checksums: ffff + 0001 wraps to 0001, frame write not summed
    host.wr(5'h05, 16'hffff, 1'b0);
    host.wr(5'h1a, 16'h0001, 1'b0);
    host.wr(5'h1e, 16'h1234, 1'b1);
    rchk("write sum", 5'h1b, 1'b0, 16'h0001);
    rchk("page word", 5'h05, 1'b0, 16'h8001);
    rchk("frame word", 5'h05, 1'b1, 16'h8001);
    rchk("read sum", 5'h1a, 1'b0, 16'h8002);
    rchk("read sum clr", 5'h1a, 1'b0, 16'h0000);
    rchk("write sum clr", 5'h1b, 1'b0, 16'h0000);
    rchk("page word", 5'h05, 1'b0, 16'h8001);
    rchk("frame sum rd", 5'h1a, 1'b1, 16'h8001);
    rchk("read sum frame clr", 5'h1a, 1'b0, 16'h0000);
    $display("test checksum done");
    // tx: six pushes into depth two, four drops saturate at three
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      txv = 1'b1;
      tns = 30'(30'h2a5c_0010 + i);
      tsec = 32'h1234_5600 + i;
    end
    @(negedge clk);
    txv = 1'b0;
    for (int k = 0; k < 2; k++) begin
      for (int w = 0; w < 4; w++) begin
        rchk("tx word", 5'h1c, 1'b0, sw(30'(30'h2a5c_0010 + k),
             32'h1234_5600 + k, (k == 0) ? 2'h3 : 2'h0, w));
      end
    end
    rchk("tx popped", 5'h1c, 1'b0, 16'h0000);
    $display("test tx done");
    // rx: three pushes, one drop
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      rxv = 1'b1;
      rns = 30'(30'h1f00_0020 + i);
      rsec = 32'h0bad_0040 + i;
      rseq = 16'(16'h7000 + i);
      rtyp = 4'hb;
      rhash = 12'(12'h3c0 + i);
    end
    @(negedge clk);
    rxv = 1'b0;
    for (int k = 0; k < 2; k++) begin
      for (int w = 0; w < 4; w++) begin
        rchk("rx word", 5'h1d, 1'b0, sw(30'(30'h1f00_0020 + k),
             32'h0bad_0040 + k, (k == 0) ? 2'h1 : 2'h0, w));
      end
      rchk("rx seq", 5'h1d, 1'b0, 16'(16'h7000 + k));
      rchk("rx type", 5'h1d, 1'b0, {4'hb, 12'(12'h3c0 + k)});
    end
    rchk("rx popped", 5'h1d, 1'b0, 16'h0000);
    $display("test rx done");
    // events: single rising on unit 2, then units 4 and 7 together
    @(negedge clk);
    {evv, ens, esec} = {1'b1, 30'h3abc_1234, 32'h0001_0002};
    {edet, erise, emask, emiss} = {8'h04, 8'h04, 8'h00, 3'h0};
    @(negedge clk);
    ens = 30'h3abd_5678;
    {edet, erise, emask, emiss} = {8'h90, 8'h80, 8'h80, 3'h3};
    @(negedge clk);
    evv = 1'b0;
    rchk("status a", 5'h1e, 1'b0, 16'h00e9);
    `CHK("held", 1'b1, eh)
    rchk("data ns lo", 5'h1f, 1'b0, 16'h1234);
    rchk("data ns hi", 5'h1f, 1'b0, 16'h3abc);
    rchk("status b", 5'h1e, 1'b0, 16'h037f);
    for (int k = 0; k < 6; k++) begin
      rchk("event data", 5'h1f, 1'b0, etab[k]);
    end
    rchk("status end", 5'h1e, 1'b0, 16'h0000);
    `CHK("held", 1'b0, eh)
    rchk("data end", 5'h1f, 1'b0, 16'h0000);
    // three falling stamps into depth two: the drop pushes misses past 7
    @(negedge clk);
    {evv, ens, edet, erise, emask, emiss} =
        {1'b1, 30'h3abd_5679, 8'h01, 8'h00, 8'h01, 3'h7};
    repeat (3) @(negedge clk);
    evv = 1'b0;
    rchk("status sat", 5'h1e, 1'b0, 16'h0701);
    rchk("status next", 5'h1e, 1'b0, 16'h0701);
    rchk("status drained", 5'h1e, 1'b0, 16'h0000);
    $display("test event done");
    finish_test();
  end
endmodule
`default_nettype wire
